// ===== design/freefall_motion_detector.sv
// Freefall and motion detector with its register set.
`timescale 1ns/100ps
`default_nettype none
`include "freefall_motion_regs.svh"
module freefall_motion_detector (
  input  wire logic                            clk_i,
  input  wire logic                            srst_i,
  input  wire logic                            sample_valid_i,
  input  wire freefall_motion_pkg::sample_type accel_x_i,
  input  wire freefall_motion_pkg::sample_type accel_y_i,
  input  wire freefall_motion_pkg::sample_type accel_z_i,
  input  wire logic [7:0]                      reg_addr_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  input  wire logic [7:0]                      reg_wdata_i,
  output logic [7:0]                           reg_rdata_o,
  output logic                                 event_active_flag_o
);
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] ths_r;
  logic [7:0] ths_nxt;
  logic [7:0] dbc_r;
  logic [7:0] dbc_nxt;
  logic       xyz_en_r;
  logic       xyz_en_nxt;
  logic [6:0] thr_msb_r [3];
  logic [6:0] thr_msb_nxt [3];
  logic [5:0] thr_lsb_r [3];
  logic [5:0] thr_lsb_nxt [3];
  logic [7:0] rdata_nxt;
  logic       rd_src;
  logic       step_r;
  freefall_motion_pkg::mag_type thr [3];
  freefall_motion_pkg::sample_type sample [3];
  logic [2:0] above;
  logic [2:0] below;
  logic [2:0] neg;
  logic [2:0] axis_en;
  logic [2:0] axis_evt;
  logic       cond;
  logic       deb_hit;
  logic       frozen;
  logic [5:0] flags_r;
  logic [5:0] flags_nxt;
  logic [5:0] flags_live;
  logic       ea_nxt;

  function automatic logic [5:0] mask_flags(input logic [5:0] f,
                                            input logic [2:0] en);
    mask_flags = f & {{2{en[2]}}, {2{en[1]}}, {2{en[0]}}};
  endfunction

  function automatic logic [2:0] thr_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - `FFMT_THS_X_MSB_ADDR;
    thr_slot = d[2:0];
  endfunction

  function automatic logic in_thr_range(input logic [7:0] a);
    in_thr_range = a >= `FFMT_THS_X_MSB_ADDR && a <= `FFMT_THS_Z_LSB_ADDR;
  endfunction

  assign axis_en = {cfg_r[`FFMT_CFG_ZEN_BIT], cfg_r[`FFMT_CFG_YEN_BIT],
                    cfg_r[`FFMT_CFG_XEN_BIT]};
  assign rd_src  = reg_rd_i && (reg_addr_i == `FFMT_SRC_ADDR);
  assign sample[0] = accel_x_i;
  assign sample[1] = accel_y_i;
  assign sample[2] = accel_z_i;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (xyz_en_r) begin
        thr[i] = {thr_msb_r[i], thr_lsb_r[i]};
      end else begin
        thr[i] = {ths_r[6:0], 6'h00};
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_axis
    axis_compare u_axis (
      .clk_i    (clk_i),
      .srst_i   (srst_i),
      .step_i   (sample_valid_i),
      .sample_i (sample[g]),
      .thr_i    (thr[g]),
      .above_o  (above[g]),
      .below_o  (below[g]),
      .neg_o    (neg[g])
    );
  end

  always_comb begin
    if (cfg_r[`FFMT_CFG_LOGIC_BIT]) begin
      axis_evt = above & axis_en;
      cond     = |axis_evt;
    end else begin
      axis_evt = below & axis_en;
      cond     = (axis_en != 3'h0) && ((below & axis_en) == axis_en);
    end
    for (int i = 0; i < 3; i++) begin
      flags_live[2*i+1] = axis_evt[i];
      flags_live[2*i]   = axis_evt[i] && neg[i];
    end
  end

  debounce_counter u_debounce (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .step_i       (step_r),
    .cond_i       (cond),
    .count_i      (dbc_r),
    .clear_mode_i (ths_r[`FFMT_THS_CLRM_BIT]),
    .hit_o        (deb_hit)
  );

  always_comb begin
    frozen = cfg_r[`FFMT_CFG_LATCH_BIT] && event_active_flag_o && !rd_src;
    if (cfg_r[`FFMT_CFG_LATCH_BIT]) begin
      ea_nxt = (event_active_flag_o && !rd_src) || deb_hit;
    end else begin
      ea_nxt = deb_hit;
    end
    if (frozen) begin
      flags_nxt = flags_r;
    end else begin
      flags_nxt = mask_flags(flags_live, axis_en);
    end
  end

  always_comb begin
    cfg_nxt    = cfg_r;
    ths_nxt    = ths_r;
    dbc_nxt    = dbc_r;
    xyz_en_nxt = xyz_en_r;
    for (int i = 0; i < 3; i++) begin
      thr_msb_nxt[i] = thr_msb_r[i];
      thr_lsb_nxt[i] = thr_lsb_r[i];
    end
    if (reg_wr_i) begin
      if (reg_addr_i == `FFMT_CFG_ADDR) begin
        cfg_nxt = {reg_wdata_i[7:3], 3'h0};
      end else if (reg_addr_i == `FFMT_THS_ADDR) begin
        ths_nxt = reg_wdata_i;
      end else if (reg_addr_i == `FFMT_DBC_ADDR) begin
        dbc_nxt = reg_wdata_i;
      end else if (in_thr_range(reg_addr_i)) begin
        for (int i = 0; i < 3; i++) begin
          if (thr_slot(reg_addr_i) == 3'(2 * i)) begin
            thr_msb_nxt[i] = reg_wdata_i[6:0];
          end
          if (thr_slot(reg_addr_i) == 3'(2 * i + 1)) begin
            thr_lsb_nxt[i] = reg_wdata_i[5:0];
          end
        end
        if (reg_addr_i == `FFMT_THS_X_MSB_ADDR) begin
          xyz_en_nxt = reg_wdata_i[`FFMT_XYZ_EN_BIT];
        end
      end
    end
  end

  always_comb begin
    rdata_nxt = reg_rdata_o;
    if (reg_rd_i) begin
      rdata_nxt = 8'h00;
      if (reg_addr_i == `FFMT_CFG_ADDR) begin
        rdata_nxt = cfg_r;
      end else if (reg_addr_i == `FFMT_SRC_ADDR) begin
        rdata_nxt = {event_active_flag_o, 1'b0,
                     mask_flags(flags_r, axis_en)};
      end else if (reg_addr_i == `FFMT_THS_ADDR) begin
        rdata_nxt = ths_r;
      end else if (reg_addr_i == `FFMT_DBC_ADDR) begin
        rdata_nxt = dbc_r;
      end else if (in_thr_range(reg_addr_i)) begin
        for (int i = 0; i < 3; i++) begin
          if (thr_slot(reg_addr_i) == 3'(2 * i)) begin
            rdata_nxt = {1'b0, thr_msb_r[i]};
          end
          if (thr_slot(reg_addr_i) == 3'(2 * i + 1)) begin
            rdata_nxt = {2'h0, thr_lsb_r[i]};
          end
        end
        if (reg_addr_i == `FFMT_THS_X_MSB_ADDR) begin
          rdata_nxt[`FFMT_XYZ_EN_BIT] = xyz_en_r;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_r               <= `FFMT_CFG_RESET;
      ths_r               <= `FFMT_THS_RESET;
      dbc_r               <= `FFMT_DBC_RESET;
      xyz_en_r            <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        thr_msb_r[i] <= 7'h00;
        thr_lsb_r[i] <= 6'h00;
      end
      reg_rdata_o         <= 8'h00;
      step_r              <= 1'b0;
      flags_r             <= 6'h00;
      event_active_flag_o <= 1'b0;
    end else begin
      cfg_r               <= cfg_nxt;
      ths_r               <= ths_nxt;
      dbc_r               <= dbc_nxt;
      xyz_en_r            <= xyz_en_nxt;
      for (int i = 0; i < 3; i++) begin
        thr_msb_r[i] <= thr_msb_nxt[i];
        thr_lsb_r[i] <= thr_lsb_nxt[i];
      end
      reg_rdata_o         <= rdata_nxt;
      step_r              <= sample_valid_i;
      flags_r             <= flags_nxt;
      event_active_flag_o <= ea_nxt;
    end
  end

  cfg_reset_a: assert property (@(posedge clk_i)
    srst_i |=> cfg_r == 8'h00 && ths_r[6:0] == 7'h00)
    else $error("configuration not cleared by reset");

  freefall_and_a: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(deb_hit) && !$past(cfg_r[`FFMT_CFG_LOGIC_BIT])
    |-> $past(axis_en != 3'h0 && (below & axis_en) == axis_en))
    else $error("freefall event without all enabled axes low");

  motion_or_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_r[`FFMT_CFG_LOGIC_BIT] && step_r && (above & axis_en) != 3'h0
    && dbc_r == 8'h00 |=> deb_hit)
    else $error("motion condition missed on an enabled axis");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_r[`FFMT_CFG_LATCH_BIT] && event_active_flag_o && !rd_src
    |=> event_active_flag_o)
    else $error("latched event flag dropped without source read");

  realtime_follow_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !cfg_r[`FFMT_CFG_LATCH_BIT] |=> event_active_flag_o == $past(deb_hit))
    else $error("unlatched event flag does not follow detection");

  flags_frozen_a: assert property (@(posedge clk_i) disable iff (srst_i)
    cfg_r[`FFMT_CFG_LATCH_BIT] && event_active_flag_o && !rd_src
    |=> flags_r == $past(flags_r))
    else $error("axis flags changed while latched");

  disabled_axis_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_src |=> (reg_rdata_o[5:0] & ~{{2{$past(axis_en[2])}},
               {2{$past(axis_en[1])}}, {2{$past(axis_en[0])}}}) == 6'h00)
    else $error("disabled axis flag read as set");

  thr_select_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 (xyz_en_r ? thr[1][12:6] == thr_msb_r[1]
                  : thr[2] == {ths_r[6:0], 6'h00}))
    else $error("threshold source not selected by per-axis enable");

  axis_excluded_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    axis_evt == ((cfg_r[`FFMT_CFG_LOGIC_BIT] ? above : below) & axis_en)
    && (axis_en != 3'h0 || !cond))
    else $error("axis enable not applied to event combination");

  src_clear_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    cfg_r[`FFMT_CFG_LATCH_BIT] && rd_src && !deb_hit
    |=> !event_active_flag_o)
    else $error("latched event flag not cleared by source read");

  hit_sets_flag_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    deb_hit |=> event_active_flag_o)
    else $error("event flag not set by debounced detection");

  flags_follow_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !cfg_r[`FFMT_CFG_LATCH_BIT]
    |=> flags_r == $past(mask_flags(flags_live, axis_en)))
    else $error("unlatched axis flags do not follow detection");

  src_layout_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    rd_src |=> reg_rdata_o[7] == $past(event_active_flag_o)
               && !reg_rdata_o[6])
    else $error("source register layout broken");

  cfg_write_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `FFMT_CFG_ADDR
    |=> cfg_r == {$past(reg_wdata_i[7:3]), 3'h0})
    else $error("configuration write not stored");

  ths_write_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `FFMT_THS_ADDR |=> ths_r == $past(reg_wdata_i))
    else $error("common threshold write not stored");

  thr_write_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `FFMT_THS_X_MSB_ADDR
    |=> xyz_en_r == $past(reg_wdata_i[`FFMT_XYZ_EN_BIT])
        && thr_msb_r[0] == $past(reg_wdata_i[6:0]))
    else $error("axis threshold write not stored");

  lsb_read_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == `FFMT_THS_Z_LSB_ADDR
    |=> reg_rdata_o == {2'h0, $past(thr_lsb_r[2])})
    else $error("axis threshold low part read wrong");
endmodule
`default_nettype wire

// ===== design/freefall_motion_regs.svh
// Register offsets, field positions, reset values and scale of the detector.
// Overview of operation
// - Freefall mode sets the event only when every enabled axis is below threshold.
// - Motion mode sets the event when any enabled axis is above threshold.
// - Common threshold at 0x17, per-axis thresholds at 0x73 through 0x78.
// - Latched mode holds the event flag until the source register is read.
// - Unlatched mode lets the event flag follow detection sample by sample.
// - Each axis has an enable; a disabled axis takes no part in detection.
// - Per-axis enable clear compares all axes with the common 7-bit threshold.
// - Per-axis enable set compares each axis with its own 13-bit threshold.
// - Latched mode freezes axis flags when the event sets, until a source read.
// - An enabled axis flags above threshold in motion, below in freefall.
// - Configuration resets to zero; bits are latch, logic, Z, Y, X, unused.
// - Debounce counter clears or decrements on a lapse, per the clear-mode bit.
// - Common threshold scale is 63 mg per bit and resets to zero.
// - Flags of a disabled axis always read as zero.
`ifndef FREEFALL_MOTION_REGS_SVH
`define FREEFALL_MOTION_REGS_SVH
`define FFMT_CFG_ADDR       8'h15
`define FFMT_SRC_ADDR       8'h16
`define FFMT_THS_ADDR       8'h17
`define FFMT_DBC_ADDR       8'h18
`define FFMT_THS_X_MSB_ADDR 8'h73
`define FFMT_THS_Z_LSB_ADDR 8'h78
`define FFMT_CFG_RESET      8'h00
`define FFMT_THS_RESET      8'h00
`define FFMT_DBC_RESET      8'h00
`define FFMT_CFG_LATCH_BIT  7
`define FFMT_CFG_LOGIC_BIT  6
`define FFMT_CFG_ZEN_BIT    5
`define FFMT_CFG_YEN_BIT    4
`define FFMT_CFG_XEN_BIT    3
`define FFMT_THS_CLRM_BIT   7
`define FFMT_XYZ_EN_BIT     7
`define FFMT_SRC_EA_BIT     7
`define FFMT_COMMON_SHIFT   6
`define FFMT_THS_MG_PER_LSB 63
`endif

// ===== design/freefall_motion_pkg.sv
// Types and shared arithmetic of the freefall and motion detector.
package freefall_motion_pkg;
  typedef logic [13:0] sample_type;
  typedef logic [12:0] mag_type;
  typedef logic [7:0]  byte_type;

  function automatic mag_type abs_mag(input sample_type s);
    logic [13:0] neg;
    neg = 14'h0000 - s;
    if (!s[13]) begin
      abs_mag = s[12:0];
    end else if (neg[13]) begin
      abs_mag = 13'h1fff;
    end else begin
      abs_mag = neg[12:0];
    end
  endfunction
endpackage

// ===== design/axis_compare.sv
// Magnitude and threshold comparison for one acceleration axis.
`timescale 1ns/100ps
`default_nettype none
module axis_compare (
  input  wire logic                         clk_i,
  input  wire logic                         srst_i,
  input  wire logic                         step_i,
  input  wire freefall_motion_pkg::sample_type sample_i,
  input  wire freefall_motion_pkg::mag_type thr_i,
  output logic                              above_o,
  output logic                              below_o,
  output logic                              neg_o
);
  freefall_motion_pkg::mag_type mag;
  logic above_nxt;
  logic below_nxt;
  logic neg_nxt;

  always_comb begin
    mag       = freefall_motion_pkg::abs_mag(sample_i);
    above_nxt = above_o;
    below_nxt = below_o;
    neg_nxt   = neg_o;
    if (step_i) begin
      above_nxt = mag > thr_i;
      below_nxt = mag < thr_i;
      neg_nxt   = sample_i[13];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      above_o <= 1'b0;
      below_o <= 1'b0;
      neg_o   <= 1'b0;
    end else begin
      above_o <= above_nxt;
      below_o <= below_nxt;
      neg_o   <= neg_nxt;
    end
  end

  magnitude_cmp_a: assert property (@(posedge clk_i) disable iff (srst_i)
    step_i |=> (above_o == ($past(mag) > $past(thr_i)))
               && (neg_o == $past(sample_i[13])))
    else $error("axis compare does not follow sample magnitude");
endmodule
`default_nettype wire

// ===== design/debounce_counter.sv
// Debounce counter for the combined freefall or motion condition.
`timescale 1ns/100ps
`default_nettype none
module debounce_counter (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       step_i,
  input  wire logic       cond_i,
  input  wire logic [7:0] count_i,
  input  wire logic       clear_mode_i,
  output logic            hit_o
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       hit_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    hit_nxt = hit_o;
    if (step_i) begin
      if (cond_i) begin
        cnt_nxt = (cnt_r < count_i) ? cnt_r + 8'h01 : count_i;
        hit_nxt = cnt_nxt == count_i;
      end else begin
        if (clear_mode_i) begin
          cnt_nxt = 8'h00;
        end else if (cnt_r != 8'h00) begin
          cnt_nxt = cnt_r - 8'h01;
        end
        hit_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r <= 8'h00;
      hit_o <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hit_o <= hit_nxt;
    end
  end

  lapse_clear_a: assert property (@(posedge clk_i) disable iff (srst_i)
    step_i && !cond_i && clear_mode_i |=> cnt_r == 8'h00)
    else $error("debounce counter not cleared on lapse");

  lapse_decrement_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    step_i && !cond_i && !clear_mode_i && cnt_r != 8'h00
    |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("debounce counter not decremented on lapse");

  hit_after_count_a: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $rose(hit_o) |-> $past(cond_i) && cnt_r == $past(count_i))
    else $error("debounce hit before count reached");
endmodule
`default_nettype wire

// ===== verification/freefall_motion_detector_tb.sv
// Self-checking testbench of the freefall and motion detector.
`timescale 1ns/100ps
`default_nettype none
`include "freefall_motion_regs.svh"
`define check_eq(name, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("wrong value %s exp %h got %h", name, exp, got); \
    end \
  end
module freefall_motion_detector_tb;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  ths;
    logic        pa;
    logic [12:0] tx;
    logic [12:0] ty;
    logic [12:0] tz;
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] z;
    logic        ea;
    logic [7:0]  src;
  } row_type;
  localparam row_type ROWS [12] = '{
    '{8'h48, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0401, 14'h0, 14'h0, 1'b1, 8'h82},
    '{8'h48, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h3bff, 14'h0, 14'h0, 1'b1, 8'h83},
    '{8'h48, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0400, 14'h0, 14'h0, 1'b0, 8'h00},
    '{8'h50, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0800, 14'h0100, 14'h0, 1'b0, 8'h00},
    '{8'h78, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0, 14'h0, 14'h0500, 1'b1, 8'ha0},
    '{8'h38, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0100, 14'h0100, 14'h0100, 1'b1, 8'haa},
    '{8'h38, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0100, 14'h0500, 14'h0100, 1'b0, 8'h22},
    '{8'h08, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0100, 14'h0500, 14'h0500, 1'b1, 8'h82},
    '{8'h00, 8'h10, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h0, 14'h0, 14'h0, 1'b0, 8'h00},
    '{8'h78, 8'h01, 1'b1, 13'h1000, 13'h0100, 13'h1fff,
      14'h0800, 14'h0200, 14'h1fff, 1'b1, 8'h88},
    '{8'h78, 8'h01, 1'b0, 13'h1000, 13'h0100, 13'h1fff,
      14'h0800, 14'h0, 14'h0, 1'b1, 8'h82},
    '{8'h48, 8'h7f, 1'b0, 13'h0, 13'h0, 13'h0,
      14'h2000, 14'h0, 14'h0, 1'b1, 8'h83}
  };
  logic                            clk_i;
  logic                            srst_i;
  logic                            sample_valid_i;
  freefall_motion_pkg::sample_type accel_x_i;
  freefall_motion_pkg::sample_type accel_y_i;
  freefall_motion_pkg::sample_type accel_z_i;
  logic [7:0]                      reg_addr_i;
  logic                            reg_wr_i;
  logic                            reg_rd_i;
  logic [7:0]                      reg_wdata_i;
  logic [7:0]                      reg_rdata_o;
  logic                            event_active_flag_o;
  int                              fails;
  int                              compares;
  logic [7:0]                      rv;
  freefall_motion_detector uut (
    .clk_i               (clk_i),
    .srst_i              (srst_i),
    .sample_valid_i      (sample_valid_i),
    .accel_x_i           (accel_x_i),
    .accel_y_i           (accel_y_i),
    .accel_z_i           (accel_z_i),
    .reg_addr_i          (reg_addr_i),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_wdata_i         (reg_wdata_i),
    .reg_rdata_o         (reg_rdata_o),
    .event_active_flag_o (event_active_flag_o)
  );
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic step(input logic [13:0] x, input logic [13:0] y,
                      input logic [13:0] z);
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    accel_x_i      <= x;
    accel_y_i      <= y;
    accel_z_i      <= z;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // Drives a run of big or zero X samples and checks the flag after each.
  task automatic run(input logic [5:0] pat, input logic [5:0] exp);
    for (int i = 5; i >= 0; i--) begin
      step(pat[i] ? 14'h0401 : 14'h0, 14'h0, 14'h0);
      `check_eq("debounce flag", exp[i], event_active_flag_o)
    end
  endtask
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    results();
  end
  initial begin
    fails          = 0;
    compares       = 0;
    srst_i         = 1'b1;
    sample_valid_i = 1'b0;
    accel_x_i      = 14'h0000;
    accel_y_i      = 14'h0000;
    accel_z_i      = 14'h0000;
    reg_addr_i     = 8'h00;
    reg_wr_i       = 1'b0;
    reg_rd_i       = 1'b0;
    reg_wdata_i    = 8'h00;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`FFMT_CFG_ADDR, rv);
    `check_eq("cfg reset", 8'h00, rv)
    rd(`FFMT_THS_ADDR, rv);
    `check_eq("ths reset", 8'h00, rv)
    rd(`FFMT_SRC_ADDR, rv);
    `check_eq("src reset", 8'h00, rv)
    wr(`FFMT_SRC_ADDR, 8'hff);
    wr(8'h20, 8'hff);
    rd(`FFMT_SRC_ADDR, rv);
    `check_eq("src read only", 8'h00, rv)
    rd(8'h20, rv);
    `check_eq("unmapped", 8'h00, rv)
    wr(`FFMT_CFG_ADDR, 8'hff);
    rd(`FFMT_CFG_ADDR, rv);
    `check_eq("cfg fields", 8'hf8, rv)
    wr(`FFMT_DBC_ADDR, 8'h00);
    foreach (ROWS[i]) begin
      wr(`FFMT_CFG_ADDR, ROWS[i].cfg);
      wr(`FFMT_THS_ADDR, ROWS[i].ths);
      wr(8'h73, {ROWS[i].pa, ROWS[i].tx[12:6]});
      wr(8'h74, {2'b00, ROWS[i].tx[5:0]});
      wr(8'h75, {1'b0, ROWS[i].ty[12:6]});
      wr(8'h76, {2'b00, ROWS[i].ty[5:0]});
      wr(8'h77, {1'b0, ROWS[i].tz[12:6]});
      wr(`FFMT_THS_Z_LSB_ADDR, {2'b00, ROWS[i].tz[5:0]});
      step(ROWS[i].x, ROWS[i].y, ROWS[i].z);
      `check_eq("row flag", ROWS[i].ea, event_active_flag_o)
      rd(`FFMT_SRC_ADDR, rv);
      `check_eq("row source", ROWS[i].src, rv)
      rd(`FFMT_THS_Z_LSB_ADDR, rv);
      `check_eq("z low threshold", 8'(ROWS[i].tz[5:0]), rv)
    end
    step(14'h0000, 14'h0, 14'h0);
    `check_eq("flag before latch", 1'b0, event_active_flag_o)
    wr(`FFMT_CFG_ADDR, 8'hc8);
    wr(`FFMT_THS_ADDR, 8'h10);
    step(14'h0401, 14'h0, 14'h0);
    step(14'h3bff, 14'h0, 14'h0);
    step(14'h0000, 14'h0, 14'h0);
    `check_eq("latched flag", 1'b1, event_active_flag_o)
    rd(`FFMT_SRC_ADDR, rv);
    `check_eq("frozen source", 8'h82, rv)
    repeat (2) @(posedge clk_i);
    #1;
    `check_eq("cleared flag", 1'b0, event_active_flag_o)
    rd(`FFMT_SRC_ADDR, rv);
    `check_eq("released source", 8'h00, rv)
    wr(`FFMT_CFG_ADDR, 8'h48);
    wr(`FFMT_DBC_ADDR, 8'h03);
    run(6'b110110, 6'b000010);
    wr(`FFMT_THS_ADDR, 8'h90);
    run(6'b000000, 6'b000000);
    run(6'b110111, 6'b000001);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    `check_eq("reset flag", 1'b0, event_active_flag_o)
    `check_eq("reset read data", 8'h00, reg_rdata_o)
    rd(`FFMT_CFG_ADDR, rv);
    `check_eq("cfg after reset", 8'h00, rv)
    results();
  end
endmodule
`default_nettype wire
